// ### logic/rxam_consts.vh
// Offsets, field positions, reset values and counts of the receive alarm register group
`ifndef RXAM_CONSTS_VH
`define RXAM_CONSTS_VH
`define RXAM_PORT_STRIDE 12'h200
`define RXAM_NUM_PORTS 8
`define RXAM_OFF_IRQ_MASK_7 12'h0a6
`define RXAM_OFF_SIG_EN_1 12'h0a8
`define RXAM_OFF_SIG_EN_2 12'h0a9
`define RXAM_OFF_SIG_EN_3 12'h0aa
`define RXAM_OFF_SIG_EN_4 12'h0ab
`define RXAM_OFF_LUP_1 12'h0ac
`define RXAM_OFF_LUP_2 12'h0ad
`define RXAM_OFF_LDN_1 12'h0ae
`define RXAM_OFF_LDN_2 12'h0af
`define RXAM_OFF_LIVE_1 12'h0b0
`define RXAM_OFF_LIVE_3 12'h0b2
`define RXAM_OFF_LATCHED_4 12'h0a3
`define RXAM_OFF_EVT_STATUS 12'h0b8
`define RXAM_OFF_CODE_LEN 12'h0b9
`define RXAM_OFF_MODE 12'h0ba
`define RXAM_BIT_BOC_DETECT 0
`define RXAM_BIT_SA_CHANGE 0
`define RXAM_BIT_SA6_CODE 1
`define RXAM_BIT_SIG_CHANGE 3
`define RXAM_BIT_REMOTE_ALARM 3
`define RXAM_BIT_ALL_ONES 2
`define RXAM_BIT_SIGNAL_LOSS 1
`define RXAM_BIT_FRAME_LOSS 0
`define RXAM_BIT_LOOP_UP 0
`define RXAM_BIT_LOOP_DOWN 1
`define RXAM_RESET_BYTE 8'h00
`define RXAM_LOS_ZEROS 192
`define RXAM_INTEG_BITS 16
`endif

// ### logic/rxam_code_det.v
// Repeating loop code detector with pattern length select and integration
`timescale 1ns/1ps
`include "rxam_consts.vh"
module rxam_code_det #(
	parameter INTEG = `RXAM_INTEG_BITS
) (
	input wire i_core_clk,
	input wire i_rst,
	input wire i_restart,
	input wire i_bit_vld,
	input wire i_bit,
	input wire [7:0] i_pat_1,
	input wire [7:0] i_pat_2,
	input wire [3:0] i_len,
	output reg o_seen_ff
);
	reg [15:0] hist_ff;
	reg [7:0] cnt_ff;
	reg [3:0] pos_ff;
	wire [15:0] nxt_hist = {hist_ff[14:0], i_bit};
	wire [15:0] pat = {i_pat_1, i_pat_2};
	reg [15:0] care;
	reg match;
	integer k;
	// Lengths below 8 compare only the top L bits of the first byte
	always @* begin
		care = 16'h0000;
		match = 1'b1;
		for (k = 0; k < 16; k = k + 1) begin
			care[k] = (i_len >= 4'h8) ? (k >= 16 - i_len) : (k >= 16 - i_len) && (k >= 8);
		end
		// Compare the last L received bits against the pattern anchored at bit 15
		for (k = 0; k < 16; k = k + 1) begin
			if (care[k] && (nxt_hist[k - 16 + i_len] != pat[k]) && (k >= 16 - i_len)) begin
				match = 1'b0;
			end
		end
	end
	always @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			hist_ff <= 16'h0000;
			cnt_ff <= 8'h00;
			pos_ff <= 4'h0;
			o_seen_ff <= 1'b0;
		end else if (i_restart) begin
			cnt_ff <= 8'h00;
			pos_ff <= 4'h0;
			o_seen_ff <= 1'b0;
		end else if (i_bit_vld) begin
			hist_ff <= nxt_hist;
			// A repeating code matches once per period; other phases only check periodicity
			if (pos_ff < i_len) begin
				pos_ff <= pos_ff + 4'h1;
			end else if ((i_len == 4'h0) || (nxt_hist[i_len] != i_bit)) begin
				cnt_ff <= 8'h00;
				o_seen_ff <= 1'b0;
			end else if (match) begin
				if (cnt_ff == INTEG[7:0]) begin
					o_seen_ff <= 1'b1;
				end else begin
					cnt_ff <= cnt_ff + 8'h01;
				end
			end
		end
	end
endmodule

// ### logic/rxam_regs.v
// Per-port receive alarm, mask and loop code register group on Avalon-MM
// Functional notes
// - Eight port copies, port n at base plus 0x200 times n minus one.
// - T1 mask bit 0 enables the bit-oriented-code detect interrupt.
// - Mask register 7 at 0x0a6 has an E1 layout, bits 1 and 0, reset zero.
// - E1 mask bit 1 enables the Sa6 valid codeword interrupt.
// - E1 mask bit 0 enables the unmasked Sa bit change interrupt.
// - Per-channel enables set signaling change flag, latched status 4 bit 3.
// - Writing first loop-up or loop-down pattern restarts that detector's integration.
// - First pattern bit 7 leads; length L ignores bits below 8 minus L.
// - Lengths 1 to 7 ignore the whole second pattern register.
// - Loop pattern registers are T1 only, 8 bits, zero, first at 0x0ac.
// - Live status 1 follows alarms unlatched; bits 7 to 4 read zero.
// - Bit 3 high while remote alarm is received.
// - Bit 2 high while unframed all-ones is received.
// - Bit 1 high after 192 consecutive zeros on the line.
// - Bit 0 high while receiver is out of frame sync.
// - Live loop-up and loop-down bits high while their pattern is received.
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`include "rxam_consts.vh"
module rxam_regs #(
	parameter NUM_PORTS = `RXAM_NUM_PORTS,
	parameter INTEG = `RXAM_INTEG_BITS
) (
	input wire i_core_clk,
	input wire i_rst,
	input wire [11:0] i_avs_address,
	input wire i_avs_read,
	input wire i_avs_write,
	input wire [31:0] i_avs_writedata,
	input wire [3:0] i_avs_byteenable,
	output reg [31:0] o_avs_readdata_ff,
	output reg o_avs_waitrequest_ff,
	input wire i_line_rx_tip,
	input wire i_line_rx_ring,
	input wire i_line_bit_vld,
	input wire i_remote_alarm_live,
	input wire i_all_ones_alarm_live,
	input wire i_frame_loss_live,
	input wire i_boc_detect_evt,
	input wire i_sa6_codeword_evt,
	input wire i_sa_bits_change_evt,
	input wire [31:0] i_sig_change_evt,
	output reg o_irq_ff
);
	localparam ST_IDLE = 2'b01;
	localparam ST_ACK = 2'b10;
	reg [1:0] st_ff;
	reg [7:0] mask7_ff;
	reg [31:0] sig_en_ff;
	reg [7:0] lup1_ff;
	reg [7:0] lup2_ff;
	reg [7:0] ldn1_ff;
	reg [7:0] ldn2_ff;
	reg [3:0] code_len_ff;
	reg e1_mode_ff;
	reg [7:0] latched4_ff;
	reg [2:0] evt_ff;
	reg [7:0] zero_cnt_ff;
	reg los_ff;
	reg [1:0] tip_sync_ff;
	reg [7:0] copy_ff [0:NUM_PORTS*32-1];
	integer p;
	reg [1:0] ring_sync_ff;
	reg [1:0] vld_sync_ff;
	reg [7:0] rd;
	wire [11:0] word = {i_avs_address[11:2], 2'b00};
	// Address bits 11:9 pick the port copy at the 0x200 stride
	wire [8:0] off = word[8:0] + {7'h00, i_avs_address[1:0]};
	wire port_ok = (i_avs_address[11:9] < NUM_PORTS);
	wire [11:0] adr = {3'h0, off};
	wire acc = (i_avs_read | i_avs_write) && (st_ff == ST_IDLE);
	// Ports 2 and up keep their own host register copies; line and event logic serve port 1
	wire [2:0] port_idx = i_avs_address[11:9];
	wire base_port = (port_idx == 3'h0);
	wire [7:0] cp_idx = {port_idx, off[4:0]};
	wire cp_wr = acc && i_avs_write && port_ok && i_avs_byteenable[0] && !base_port;
	wire [7:0] cp_byte = copy_ff[cp_idx];
	wire cp_e1 = copy_ff[{port_idx, 5'h1a}][0];
	wire cp_loop = (adr >= `RXAM_OFF_LUP_1) && (adr <= `RXAM_OFF_LDN_2);
	wire cp_sig = (adr >= `RXAM_OFF_SIG_EN_1) && (adr <= `RXAM_OFF_SIG_EN_4);
	wire cp_rw = (adr == `RXAM_OFF_IRQ_MASK_7) || cp_sig || (cp_loop && !cp_e1)
		|| (adr == `RXAM_OFF_CODE_LEN) || (adr == `RXAM_OFF_MODE);
	wire [7:0] cp_rd = cp_rw ? cp_byte : 8'h00;
	wire wr = acc && i_avs_write && port_ok && i_avs_byteenable[0] && base_port;
	wire rx_bit = tip_sync_ff[1] | ring_sync_ff[1];
	wire wr_lup1 = wr && (adr == `RXAM_OFF_LUP_1) && !e1_mode_ff;
	wire wr_ldn1 = wr && (adr == `RXAM_OFF_LDN_1) && !e1_mode_ff;
	wire loop_up_seen;
	wire loop_down_seen;
	wire [7:0] live1 = {4'h0, i_remote_alarm_live, i_all_ones_alarm_live,
		los_ff, i_frame_loss_live};
	wire sig_hit = |(i_sig_change_evt & sig_en_ff & {e1_mode_ff, 31'h7fffffff} & 32'h00ffffff)
		| (|(i_sig_change_evt[31:24] & sig_en_ff[31:24]) & e1_mode_ff);
	wire [2:0] evt_set = e1_mode_ff ? {1'b0, i_sa6_codeword_evt, i_sa_bits_change_evt}
		: {1'b0, 1'b0, i_boc_detect_evt};
	wire [2:0] evt_clr = (wr && (adr == `RXAM_OFF_EVT_STATUS)) ? i_avs_writedata[2:0] : 3'h0;
	wire [7:0] l4_clr = (wr && (adr == `RXAM_OFF_LATCHED_4)) ? i_avs_writedata[7:0] : 8'h00;
	wire [2:0] mask_ev = e1_mode_ff ? {1'b0, mask7_ff[`RXAM_BIT_SA6_CODE],
		mask7_ff[`RXAM_BIT_SA_CHANGE]} : {2'b00, mask7_ff[`RXAM_BIT_BOC_DETECT]};
	rxam_code_det #(.INTEG(INTEG)) u_lup (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_restart(wr_lup1),
		.i_bit_vld(vld_sync_ff[1]),
		.i_bit(rx_bit),
		.i_pat_1(lup1_ff),
		.i_pat_2(lup2_ff),
		.i_len(code_len_ff),
		.o_seen_ff(loop_up_seen)
	);
	rxam_code_det #(.INTEG(INTEG)) u_ldn (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_restart(wr_ldn1),
		.i_bit_vld(vld_sync_ff[1]),
		.i_bit(rx_bit),
		.i_pat_1(ldn1_ff),
		.i_pat_2(ldn2_ff),
		.i_len(code_len_ff),
		.o_seen_ff(loop_down_seen)
	);
	// Line pins come from the recovered clock domain
	always @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			tip_sync_ff <= 2'h0;
			ring_sync_ff <= 2'h0;
			vld_sync_ff <= 2'h0;
		end else begin
			tip_sync_ff <= {tip_sync_ff[0], i_line_rx_tip};
			ring_sync_ff <= {ring_sync_ff[0], i_line_rx_ring};
			vld_sync_ff <= {vld_sync_ff[0], i_line_bit_vld};
		end
	end
	// Consecutive zero counter for loss of signal
	always @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			zero_cnt_ff <= 8'h00;
			los_ff <= 1'b0;
		end else if (vld_sync_ff[1]) begin
			if (rx_bit) begin
				zero_cnt_ff <= 8'h00;
				los_ff <= 1'b0;
			end else if (zero_cnt_ff == (`RXAM_LOS_ZEROS - 1)) begin
				los_ff <= 1'b1;
			end else begin
				zero_cnt_ff <= zero_cnt_ff + 8'h01;
			end
		end
	end
	// Host writable registers
	always @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			mask7_ff <= `RXAM_RESET_BYTE;
			sig_en_ff <= 32'h00000000;
			lup1_ff <= `RXAM_RESET_BYTE;
			lup2_ff <= `RXAM_RESET_BYTE;
			ldn1_ff <= `RXAM_RESET_BYTE;
			ldn2_ff <= `RXAM_RESET_BYTE;
			code_len_ff <= 4'h0;
			e1_mode_ff <= 1'b0;
		end else if (wr) begin
			if (adr == `RXAM_OFF_IRQ_MASK_7) begin
				mask7_ff <= e1_mode_ff ? {6'h00, i_avs_writedata[1:0]} : i_avs_writedata[7:0];
			end else if (adr == `RXAM_OFF_SIG_EN_1) begin
				sig_en_ff[7:0] <= i_avs_writedata[7:0];
			end else if (adr == `RXAM_OFF_SIG_EN_2) begin
				sig_en_ff[15:8] <= i_avs_writedata[7:0];
			end else if (adr == `RXAM_OFF_SIG_EN_3) begin
				sig_en_ff[23:16] <= i_avs_writedata[7:0];
			end else if (adr == `RXAM_OFF_SIG_EN_4) begin
				sig_en_ff[31:24] <= i_avs_writedata[7:0];
			end else if (adr == `RXAM_OFF_LUP_1 && !e1_mode_ff) begin
				lup1_ff <= i_avs_writedata[7:0];
			end else if (adr == `RXAM_OFF_LUP_2 && !e1_mode_ff) begin
				lup2_ff <= i_avs_writedata[7:0];
			end else if (adr == `RXAM_OFF_LDN_1 && !e1_mode_ff) begin
				ldn1_ff <= i_avs_writedata[7:0];
			end else if (adr == `RXAM_OFF_LDN_2 && !e1_mode_ff) begin
				ldn2_ff <= i_avs_writedata[7:0];
			end else if (adr == `RXAM_OFF_CODE_LEN) begin
				code_len_ff <= i_avs_writedata[3:0];
			end else if (adr == `RXAM_OFF_MODE) begin
				e1_mode_ff <= i_avs_writedata[0];
			end
		end
	end
	// Host register copies of the other ports
	always @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			for (p = 0; p < NUM_PORTS * 32; p = p + 1) begin
				copy_ff[p] <= `RXAM_RESET_BYTE;
			end
		end else if (cp_wr && cp_rw) begin
			if ((adr == `RXAM_OFF_IRQ_MASK_7) && cp_e1) begin
				copy_ff[cp_idx] <= {6'h00, i_avs_writedata[1:0]};
			end else if (adr == `RXAM_OFF_CODE_LEN) begin
				copy_ff[cp_idx] <= {4'h0, i_avs_writedata[3:0]};
			end else if (adr == `RXAM_OFF_MODE) begin
				copy_ff[cp_idx] <= {7'h00, i_avs_writedata[0]};
			end else begin
				copy_ff[cp_idx] <= i_avs_writedata[7:0];
			end
		end
	end
	// Sticky flags, a new event wins over a same-cycle clear
	always @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			latched4_ff <= 8'h00;
			evt_ff <= 3'h0;
			o_irq_ff <= 1'b0;
		end else begin
			latched4_ff <= (latched4_ff & ~l4_clr) | ({7'h00, sig_hit} << `RXAM_BIT_SIG_CHANGE);
			evt_ff <= (evt_ff & ~evt_clr) | evt_set;
			o_irq_ff <= |(evt_ff & mask_ev) | latched4_ff[`RXAM_BIT_SIG_CHANGE];
		end
	end
	// Read mux
	always @* begin
		rd = 8'h00;
		if (!base_port) begin
			rd = cp_rd;
		end else if (adr == `RXAM_OFF_IRQ_MASK_7) begin
			rd = mask7_ff;
		end else if (adr == `RXAM_OFF_SIG_EN_1) begin
			rd = sig_en_ff[7:0];
		end else if (adr == `RXAM_OFF_SIG_EN_2) begin
			rd = sig_en_ff[15:8];
		end else if (adr == `RXAM_OFF_SIG_EN_3) begin
			rd = sig_en_ff[23:16];
		end else if (adr == `RXAM_OFF_SIG_EN_4) begin
			rd = sig_en_ff[31:24];
		end else if (adr == `RXAM_OFF_LUP_1) begin
			rd = e1_mode_ff ? 8'h00 : lup1_ff;
		end else if (adr == `RXAM_OFF_LUP_2) begin
			rd = e1_mode_ff ? 8'h00 : lup2_ff;
		end else if (adr == `RXAM_OFF_LDN_1) begin
			rd = e1_mode_ff ? 8'h00 : ldn1_ff;
		end else if (adr == `RXAM_OFF_LDN_2) begin
			rd = e1_mode_ff ? 8'h00 : ldn2_ff;
		end else if (adr == `RXAM_OFF_LIVE_1) begin
			rd = live1;
		end else if (adr == `RXAM_OFF_LIVE_3) begin
			rd = {6'h00, loop_down_seen, loop_up_seen};
		end else if (adr == `RXAM_OFF_LATCHED_4) begin
			rd = latched4_ff;
		end else if (adr == `RXAM_OFF_EVT_STATUS) begin
			rd = {5'h00, evt_ff};
		end else if (adr == `RXAM_OFF_CODE_LEN) begin
			rd = {4'h0, code_len_ff};
		end else if (adr == `RXAM_OFF_MODE) begin
			rd = {7'h00, e1_mode_ff};
		end
	end
	// Avalon slave: one wait cycle, answer on the second edge
	always @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			st_ff <= ST_IDLE;
			o_avs_waitrequest_ff <= 1'b1;
			o_avs_readdata_ff <= 32'h00000000;
		end else begin
			case (st_ff)
				ST_IDLE: begin
					if (i_avs_read | i_avs_write) begin
						st_ff <= ST_ACK;
						o_avs_waitrequest_ff <= 1'b0;
						o_avs_readdata_ff <= port_ok ? {24'h000000, rd} : 32'h00000000;
					end
				end
				ST_ACK: begin
					st_ff <= ST_IDLE;
					o_avs_waitrequest_ff <= 1'b1;
				end
				default: begin
					st_ff <= ST_IDLE;
					o_avs_waitrequest_ff <= 1'b1;
				end
			endcase
		end
	end
endmodule

// ### test/rxam_regs_monitor.sv
// Checker of bus timing, readback and interrupt causes on the register group ports
`timescale 1ns/1ps
module rxam_regs_monitor #(
	parameter NUM_PORTS = 8,
	parameter INTEG = 16
) (
	input wire i_core_clk,
	input wire i_rst,
	input wire [11:0] i_avs_address,
	input wire i_avs_read,
	input wire i_avs_write,
	input wire [31:0] o_avs_readdata_ff,
	input wire o_avs_waitrequest_ff,
	input wire i_remote_alarm_live,
	input wire i_all_ones_alarm_live,
	input wire i_boc_detect_evt,
	input wire i_sa6_codeword_evt,
	input wire i_sa_bits_change_evt,
	input wire [31:0] i_sig_change_evt,
	input wire o_irq_ff
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	wire req = i_avs_read | i_avs_write;
	wire evt = i_boc_detect_evt | i_sa6_codeword_evt | i_sa_bits_change_evt | (|i_sig_change_evt);
	wire [1:0] alm = {i_remote_alarm_live, i_all_ones_alarm_live};
	wire [11:0] adr = i_avs_address;
	wire ans = !o_avs_waitrequest_ff;
	a_wait_one_cycle: assert property ($fell(o_avs_waitrequest_ff) |=> o_avs_waitrequest_ff)
		else $error("waitrequest low longer than one cycle");
	a_wait_needs_req: assert property ($fell(o_avs_waitrequest_ff) |-> $past(req))
		else $error("answer without a request");
	a_req_answered: assert property (req && !$past(req) |-> ##[1:2] ans)
		else $error("request not answered in time");
	a_rdata_stands: assert property (!ans && $past(o_avs_waitrequest_ff)
		|-> $stable(o_avs_readdata_ff))
		else $error("read data changed between answers");
	a_live_alarm_bits: assert property (ans && $past(i_avs_read) && $past(adr) == 12'h0b0
		&& $past(alm) == alm && $past(alm, 2) == alm
		|-> o_avs_readdata_ff[31:2] == {28'h0, alm})
		else $error("live alarm bits do not follow inputs");
	a_unmapped_zero: assert property (ans && $past(i_avs_read) && $past(adr) == 12'h1ff
		|-> o_avs_readdata_ff == 32'h0)
		else $error("unmapped offset read not zero");
	a_irq_has_cause: assert property ($rose(o_irq_ff) |-> $past(i_avs_write, 2) || $past(evt, 2))
		else $error("interrupt rose without event or write");
	a_irq_drop_write: assert property ($fell(o_irq_ff) |-> $past(i_avs_write, 2))
		else $error("interrupt fell without a host write");
	c_live_read: cover property (ans && $past(i_avs_read) && $past(adr) == 12'h0b0);
	c_irq_rise: cover property ($rose(o_irq_ff));
	c_unmapped: cover property (ans && $past(adr) == 12'h1ff);
endmodule

// ### test/rxam_line_model.sv
// Remote line equipment sending repeating bit patterns on the receive pair
`timescale 1ns/1ps
module rxam_line_model (
	input wire logic i_core_clk,
	output logic o_tip,
	output logic o_ring,
	output logic o_vld
);
	initial begin
		o_tip = 1'b1;
		o_ring = 1'b0;
		o_vld = 1'b0;
	end
	// Idle line shows the inverse of the last bit so nothing stale is mistaken for data
	task send(input logic [7:0] pat, input int len, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge i_core_clk);
			o_tip <= pat[7 - (i % len)];
			o_vld <= 1'b1;
		end
		@(posedge i_core_clk);
		o_vld <= 1'b0;
		o_tip <= ~o_tip;
		repeat (4) @(posedge i_core_clk);
	endtask
endmodule

// ### test/tb.sv
// Register group testbench: bus tasks, alarm, loop code and interrupt sequences
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module tb;
	logic i_core_clk, i_rst, rd, wr, tip, ring, vld, ra, ao, fl, boc, sa6, sax, irq, wq;
	logic [11:0] adr;
	logic [31:0] wd, rq, sig;
	logic [7:0] q;
	int n_errors, num_checks;
	rxam_regs #(.INTEG(2)) dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_avs_address(adr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'h1),
		.o_avs_readdata_ff(rq), .o_avs_waitrequest_ff(wq), .i_line_rx_tip(tip),
		.i_line_rx_ring(ring), .i_line_bit_vld(vld), .i_remote_alarm_live(ra),
		.i_all_ones_alarm_live(ao), .i_frame_loss_live(fl), .i_boc_detect_evt(boc),
		.i_sa6_codeword_evt(sa6), .i_sa_bits_change_evt(sax), .i_sig_change_evt(sig),
		.o_irq_ff(irq));
	rxam_line_model line (.i_core_clk(i_core_clk), .o_tip(tip), .o_ring(ring), .o_vld(vld));
	initial begin
		i_core_clk = 1'b0;
		forever #5 i_core_clk = ~i_core_clk;
	end
	task test_done;
		if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task bus(input logic w, input logic [11:0] a, input logic [7:0] d);
		int t;
		@(posedge i_core_clk);
		adr <= a;
		wr <= w;
		rd <= !w;
		wd <= {24'h0, d};
		t = 0;
		do begin
			@(posedge i_core_clk);
			t++;
		end while (wq !== 1'b0 && t < 20);
		if (wq !== 1'b0) n_errors++;
		q = rq[7:0];
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task rc(input logic [11:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		`CHK(q, e)
	endtask
	task ev(input logic [2:0] k, input logic [31:0] s, input logic e);
		@(posedge i_core_clk);
		{sax, sa6, boc} <= k;
		sig <= s;
		@(posedge i_core_clk);
		{sax, sa6, boc} <= 3'h0;
		sig <= 32'h0;
		repeat (3) @(posedge i_core_clk);
		`CHK(irq, e)
	endtask
	initial begin
		#50us;
		n_errors++;
		test_done;
	end
	initial begin
		{rd, wr, ra, ao, fl, boc, sa6, sax} = 8'h0;
		adr = 12'h0;
		wd = 32'h0;
		sig = 32'h0;
		i_rst = 1'b1;
		repeat (3) @(posedge i_core_clk);
		i_rst <= 1'b0;
		rc(12'h0a6, 8'h00);
		for (int i = 8; i < 16; i++) rc(12'h0a0 + i[11:0], 8'h00);
		rc(12'h0b0, 8'h00);
		rc(12'h1ff, 8'h00);
		bus(1'b1, 12'heac, 8'h5a);
		rc(12'h0ac, 8'h00);
		rc(12'h6ac, 8'h00);
		rc(12'heac, 8'h5a);
		bus(1'b1, 12'h0a6, 8'h01);
		rc(12'h0a6, 8'h01);
		ev(3'b001, 32'h0, 1'b1);
		rc(12'h0b8, 8'h01);
		bus(1'b1, 12'h0b8, 8'h01);
		repeat (3) @(posedge i_core_clk);
		`CHK(irq, 1'b0)
		bus(1'b1, 12'h0a6, 8'h00);
		ev(3'b001, 32'h0, 1'b0);
		bus(1'b1, 12'h0b8, 8'h01);
		bus(1'b1, 12'h0a9, 8'h02);
		ev(3'b000, 32'h100, 1'b0);
		ev(3'b000, 32'h200, 1'b1);
		rc(12'h0a3, 8'h08);
		bus(1'b1, 12'h0a3, 8'h08);
		bus(1'b1, 12'h0a9, 8'h00);
		ra <= 1'b1;
		fl <= 1'b1;
		rc(12'h0b0, 8'h09);
		ra <= 1'b0;
		fl <= 1'b0;
		ao <= 1'b1;
		rc(12'h0b0, 8'h04);
		ao <= 1'b0;
		line.send(8'h00, 1, 191);
		rc(12'h0b0, 8'h00);
		line.send(8'h00, 1, 1);
		rc(12'h0b0, 8'h02);
		line.send(8'h80, 1, 1);
		rc(12'h0b0, 8'h00);
		bus(1'b1, 12'h0b9, 8'h03);
		bus(1'b1, 12'h0ac, 8'ha7);
		bus(1'b1, 12'h0ad, 8'hff);
		rc(12'h0ad, 8'hff);
		line.send(8'ha0, 3, 48);
		rc(12'h0b2, 8'h01);
		bus(1'b1, 12'h0ac, 8'ha7);
		rc(12'h0b2, 8'h00);
		bus(1'b1, 12'h0ba, 8'h01);
		bus(1'b1, 12'h0a6, 8'hff);
		rc(12'h0a6, 8'h03);
		rc(12'h0ac, 8'h00);
		ev(3'b010, 32'h0, 1'b1);
		bus(1'b1, 12'h0b8, 8'h02);
		ev(3'b100, 32'h0, 1'b1);
		bus(1'b1, 12'h0b8, 8'h01);
		repeat (3) @(posedge i_core_clk);
		`CHK(irq, 1'b0)
		test_done;
	end
endmodule
bind rxam_regs rxam_regs_monitor #(.NUM_PORTS(NUM_PORTS), .INTEG(INTEG)) u_mon (
	.i_core_clk(i_core_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
	.i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata_ff(o_avs_readdata_ff),
	.o_avs_waitrequest_ff(o_avs_waitrequest_ff), .i_remote_alarm_live(i_remote_alarm_live),
	.i_all_ones_alarm_live(i_all_ones_alarm_live), .i_boc_detect_evt(i_boc_detect_evt),
	.i_sa6_codeword_evt(i_sa6_codeword_evt), .i_sa_bits_change_evt(i_sa_bits_change_evt),
	.i_sig_change_evt(i_sig_change_evt), .o_irq_ff(o_irq_ff));
